// ### src/timer_counter_pkg.sv
// Purpose: Shared constants and types for the 16-bit timer/counter base
// Assumes: Single clock domain, plain register port with 5-bit word address
// Notes:   Each register is one 16-bit word at a word address
package timer_counter_pkg;

   localparam int DATA_W     = 16;
   localparam int ADDR_W     = 5;
   localparam int NUM_TAPS   = 11;   // Prescaler outputs 1, 1/2 ... 1/1024
   localparam int NUM_EVENTS = 4;    // Event channels reaching this timer
   localparam int MAX_CH     = 4;

   ////////////////////////////////////////////////////////////////////////
   // Register word addresses
   localparam logic [4:0] CTRL_ADDR       = 5'h00;
   localparam logic [4:0] STATUS_ADDR     = 5'h01;
   localparam logic [4:0] COUNT_ADDR      = 5'h02;
   localparam logic [4:0] PERIOD_ADDR     = 5'h03;
   localparam logic [4:0] PERIOD_BUF_ADDR = 5'h04;
   localparam logic [4:0] CC_BASE_ADDR    = 5'h05;   // Channels at 05..08
   localparam logic [4:0] CCBUF_BASE_ADDR = 5'h09;   // Buffers at 09..0C

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [15:0] CTRL_RESET   = 16'h0000;
   localparam logic [15:0] COUNT_RESET  = 16'h0000;
   localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
   localparam logic [15:0] CC_RESET     = 16'h0000;

   ////////////////////////////////////////////////////////////////////////
   // Count source codes: 0 none, 1..11 prescaler taps, 12..15 event channels
   localparam logic [3:0] SRC_NONE        = 4'h0;
   localparam logic [3:0] SRC_PRESC_FIRST = 4'h1;
   localparam logic [3:0] SRC_PRESC_LAST  = 4'hB;
   localparam logic [3:0] SRC_EVENT_FIRST = 4'hC;

   // Event action codes
   localparam logic [2:0] EVENT_ACTION_SELECT_OFF    = 3'h0;
   localparam logic [2:0] EVENT_ACTION_SELECT_UPDOWN = 3'h1;

   // Status word bit positions
   localparam int ST_PERIOD_BV = 0;   // Channel flags follow at 1..4
   localparam int ST_CC_BV     = 1;
   localparam int ST_RUNNING   = 5;
   localparam int ST_BOTTOM    = 6;
   localparam int ST_MAX       = 7;
   localparam int ST_TOP       = 8;

   // Control word, 16 bits, msb first
   typedef struct packed {
      logic [3:0] event_source_select;
      logic [2:0] event_action_select;
      logic       split;
      logic       capture;
      logic       update_at_bottom;
      logic       top_from_cca;
      logic       count_down;
      logic [3:0] count_source_select;
   } ctrl_s;

   // Events toward the event system
   typedef struct packed {
      logic       overflow;
      logic       error;
      logic       update;
      logic [3:0] compare;
      logic [3:0] compare_hi;
   } events_s;

endpackage

// ### src/timer_counter_base.sv
// Purpose: Base counter of a 16-bit timer/counter with period and compare
// Assumes: Prescaler strobes and event channels come from same-clock logic
// Notes:   Waveform output and capture actions live outside this block
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ns

// Functional notes
// - Count, period, compare and buffers are 16-bit
// - Four channels for first type, two otherwise
// - Each buffer has its own valid flag
// - BOTTOM when count is zero
// - MAX when count is all ones
// - TOP is period or channel A compare
// - UPDATE at BOTTOM or TOP, mode chosen, none in split mode
// - Count compared with zero and TOP continuously
// - Count compared with each channel, raising events
// - Per-channel, overflow and error events provided
// - Compare or capture, never both together
// - Shared prescaler, ratios 1 to 1/1024 selectable
// - Source selects prescaler tap or event channel
// - Event selection and action steer the counter
// - After reset no source, counter stopped
// - Split mode, first type only, two 8-bit counters
// - Up clears after TOP, down reloads period
// - Buffer write sets flag, UPDATE copies, clears; channel buffers hold in capture
// - Software count write overrides counting that cycle
module timer_counter_base
   import timer_counter_pkg::*;
#(
   parameter bit FOUR_CHANNELS = 1'b1
) (
   input  wire logic                  CLK,
   input  wire logic                  RST,
   input  wire logic [ADDR_W-1:0]     ADDR,
   input  wire logic [DATA_W-1:0]     WDATA,
   input  wire logic                  WR,
   input  wire logic                  RD,
   output      logic [DATA_W-1:0]     RDATA,
   input  wire logic [NUM_TAPS-1:0]   PRESCALE_TICK,
   input  wire logic [NUM_EVENTS-1:0] EVENT_IN,
   output      events_s               EVENTS_OUT
);

   localparam int NCH = FOUR_CHANNELS ? 4 : 2;

   ctrl_s              ctrl;
   logic [15:0]        cnt;
   logic [15:0]        period;
   logic [15:0]        period_buf;
   logic               period_bv;
   logic [15:0]        cc     [MAX_CH];
   logic [15:0]        cc_buf [MAX_CH];
   logic [MAX_CH-1:0]  cc_bv;
   logic               tick;
   logic               step;
   logic               down;
   logic               split_on;
   logic [15:0]        top;
   logic               at_top;
   logic               at_bottom;
   logic               at_max;
   logic               update;
   logic [15:0]        next_cnt;
   logic               wr_count;
   logic [1:0]         ev_n;
   logic [1:0]         ev_n1;
   ctrl_s              wr_ctrl;

   // Address match for one register word, used by both write and read decode
   function automatic logic hit(input logic [4:0] a, input logic [4:0] target);
      hit = (a == target);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Count source and event action
   assign ev_n     = ctrl.event_source_select[1:0];
   assign ev_n1    = ev_n + 2'h1;
   assign split_on = FOUR_CHANNELS && ctrl.split;
   assign wr_count = WR && hit(ADDR, COUNT_ADDR);
   assign wr_ctrl  = ctrl_s'(WDATA);   // Incoming control word, for the error check

   // Source decode; code zero leaves the counter without a clock
   always_comb begin
      tick = 1'b0;
      if (ctrl.count_source_select >= SRC_PRESC_FIRST &&
          ctrl.count_source_select <= SRC_PRESC_LAST) begin
         tick = PRESCALE_TICK[ctrl.count_source_select - SRC_PRESC_FIRST];
      end else if (ctrl.count_source_select >= SRC_EVENT_FIRST) begin
         tick = EVENT_IN[ctrl.count_source_select[1:0]];
      end
   end

   // Event n enables counting, event n+1 high selects up
   always_comb begin
      step = tick;
      down = ctrl.count_down;
      if (ctrl.event_action_select == EVENT_ACTION_SELECT_UPDOWN) begin
         step = tick && EVENT_IN[ev_n];
         down = !EVENT_IN[ev_n1];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Limit detection, always live so software sees it too
   assign top       = ctrl.top_from_cca ? cc[0] : period;
   assign at_top    = (cnt == top);
   assign at_bottom = (cnt == 16'h0000);
   assign at_max    = (cnt == 16'hFFFF);
   assign update    = step && !split_on &&
                      (ctrl.update_at_bottom ? at_bottom : at_top);

   // Next count; split halves both count down on their own byte period
   always_comb begin
      next_cnt = cnt;
      if (split_on) begin
         next_cnt[7:0]  = (cnt[7:0] == 8'h00) ? period[7:0] : cnt[7:0] - 8'h01;
         next_cnt[15:8] = (cnt[15:8] == 8'h00) ? period[15:8] : cnt[15:8] - 8'h01;
      end else if (down) begin
         next_cnt = at_bottom ? period : cnt - 16'h0001;
      end else begin
         next_cnt = at_top ? 16'h0000 : cnt + 16'h0001;
      end
   end

   // Counter; a software write beats any step in the same cycle
   always_ff @(posedge CLK) begin
      if (RST) begin
         cnt <= COUNT_RESET;
      end else if (wr_count) begin
         cnt <= WDATA;
      end else if (step) begin
         cnt <= next_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control word; reset leaves no source selected
   always_ff @(posedge CLK) begin
      if (RST) begin
         ctrl <= ctrl_s'(CTRL_RESET);
      end else if (WR && hit(ADDR, CTRL_ADDR)) begin
         ctrl <= ctrl_s'(WDATA);
      end
   end

   // Period with buffer; a fresh buffer write keeps its flag over UPDATE
   always_ff @(posedge CLK) begin
      if (RST) begin
         period     <= PERIOD_RESET;
         period_buf <= PERIOD_RESET;
         period_bv  <= 1'b0;
      end else begin
         if (WR && hit(ADDR, PERIOD_ADDR)) begin
            period <= WDATA;
         end else if (update && period_bv) begin
            period <= period_buf;
         end
         if (WR && hit(ADDR, PERIOD_BUF_ADDR)) begin
            period_buf <= WDATA;
            period_bv  <= 1'b1;
         end else if (update) begin
            period_bv  <= 1'b0;
         end
      end
   end

   // Compare channels; missing channels of the second type stay zero
   genvar g;
   generate
      for (g = 0; g < MAX_CH; g++) begin : gen_ch
         if (g < NCH) begin : gen_on
            always_ff @(posedge CLK) begin
               if (RST) begin
                  cc[g]     <= CC_RESET;
                  cc_buf[g] <= CC_RESET;
                  cc_bv[g]  <= 1'b0;
               end else begin
                  if (WR && hit(ADDR, CC_BASE_ADDR + 5'(g))) begin
                     cc[g] <= WDATA;
                  end else if (update && cc_bv[g] && !ctrl.capture) begin
                     cc[g] <= cc_buf[g];
                  end
                  if (WR && hit(ADDR, CCBUF_BASE_ADDR + 5'(g))) begin
                     cc_buf[g] <= WDATA;
                     cc_bv[g]  <= 1'b1;
                  end else if (update && !ctrl.capture) begin
                     cc_bv[g]  <= 1'b0;
                  end
               end
            end
         end else begin : gen_off
            assign cc[g]     = CC_RESET;
            assign cc_buf[g] = CC_RESET;
            assign cc_bv[g]  = 1'b0;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Events, registered; compare is silenced in capture mode
   always_ff @(posedge CLK) begin
      if (RST) begin
         EVENTS_OUT <= '0;
      end else begin
         EVENTS_OUT.update   <= update;
         EVENTS_OUT.overflow <= step && (split_on ? (cnt[7:0] == 8'h00) :
                                          (down ? at_bottom : at_top));
         // Event action with a prescaler source cannot count sensibly;
         // flagged from the written word so software sees it at once
         EVENTS_OUT.error    <= WR && hit(ADDR, CTRL_ADDR) &&
                                wr_ctrl.event_action_select != EVENT_ACTION_SELECT_OFF &&
                                wr_ctrl.count_source_select < SRC_EVENT_FIRST;
         for (int i = 0; i < MAX_CH; i++) begin
            EVENTS_OUT.compare[i]    <= step && !ctrl.capture && (i < NCH) &&
                                        (split_on ? cnt[7:0] == cc[i][7:0]
                                                  : cnt == cc[i]);
            EVENTS_OUT.compare_hi[i] <= step && !ctrl.capture && split_on &&
                                        cnt[15:8] == cc[i][15:8];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read port; data stand only in the cycle after the strobe
   always_ff @(posedge CLK) begin
      if (RST) begin
         RDATA <= 16'h0000;
      end else if (!RD) begin
         RDATA <= 16'h0000;
      end else begin
         RDATA <= 16'h0000;
         if (hit(ADDR, CTRL_ADDR))       RDATA <= ctrl;
         if (hit(ADDR, COUNT_ADDR))      RDATA <= cnt;
         if (hit(ADDR, PERIOD_ADDR))     RDATA <= period;
         if (hit(ADDR, PERIOD_BUF_ADDR)) RDATA <= period_buf;
         if (hit(ADDR, STATUS_ADDR)) begin
            RDATA[ST_PERIOD_BV]          <= period_bv;
            RDATA[ST_CC_BV +: MAX_CH]    <= cc_bv;
            RDATA[ST_RUNNING]            <= ctrl.count_source_select != SRC_NONE;
            RDATA[ST_BOTTOM]             <= at_bottom;
            RDATA[ST_MAX]                <= at_max;
            RDATA[ST_TOP]                <= at_top;
         end
         for (int i = 0; i < MAX_CH; i++) begin
            if (hit(ADDR, CC_BASE_ADDR + 5'(i)))    RDATA <= cc[i];
            if (hit(ADDR, CCBUF_BASE_ADDR + 5'(i))) RDATA <= cc_buf[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   // Counting, reload and software override
   count_wrap_a: assert property (step && !down && !split_on && at_top && !wr_count
      |=> cnt == 16'h0000) else $error("count did not clear after TOP");
   count_reload_a: assert property (step && down && !split_on && at_bottom && !wr_count
      |=> cnt == $past(period)) else $error("count did not reload period");
   count_write_a: assert property (wr_count |=> cnt == $past(WDATA))
      else $error("count write lost");
   stopped_a: assert property (ctrl.count_source_select == SRC_NONE && !wr_count
      |=> $stable(cnt)) else $error("count moved with no source");
   // Buffer flags, read port and compare events
   bv_set_a: assert property (WR && hit(ADDR, PERIOD_BUF_ADDR)
      |=> period_bv && period_buf == $past(WDATA)) else $error("buffer flag not set");
   bv_copy_a: assert property (update && period_bv && !WR
      |=> !period_bv && period == $past(period_buf)) else $error("update copy missing");
   read_count_a: assert property (RD && hit(ADDR, COUNT_ADDR) && !wr_count
      |=> RDATA == $past(cnt)) else $error("count read wrong");
   compare_hit_a: assert property (step && !ctrl.capture && !split_on && cnt == cc[1]
      |=> EVENTS_OUT.compare[1]) else $error("compare event missing");
   capture_quiet_a: assert property (ctrl.capture
      |=> EVENTS_OUT.compare == 4'h0) else $error("compare in capture mode");
   // Absent channels of the second type must stay silent
   two_channel_a: assert property (!FOUR_CHANNELS
      |-> EVENTS_OUT.compare[3:2] == 2'b00 && cc_bv[3:2] == 2'b00)
      else $error("absent channel active");
   bottom_flag_a: assert property (RD && hit(ADDR, STATUS_ADDR) && at_bottom
      |=> RDATA[ST_BOTTOM]) else $error("bottom not shown");

   // Split halves, channel transfer and overflow pulse
   // Only channel 0 is checked; the others share the same generate body
   split_reload_a: assert property (step && split_on && cnt[7:0] == 8'h00 && !wr_count
      |=> cnt[7:0] == $past(period[7:0])) else $error("split low byte did not reload");
   cc_copy_a: assert property (update && cc_bv[0] && !ctrl.capture && !WR
      |=> !cc_bv[0] && cc[0] == $past(cc_buf[0])) else $error("channel copy missing");
   overflow_a: assert property (step && !down && !split_on && at_top
      |=> EVENTS_OUT.overflow) else $error("overflow event missing");
   bottom_update_a: assert property (step && !split_on && ctrl.update_at_bottom
      && at_bottom |-> update) else $error("no update at bottom");

   // Main scenarios the bench should reach
   wrap_c: cover property (step && !down && at_top ##1 cnt == 16'h0000);
   update_c: cover property (period_bv ##[1:50] update);
   split_c: cover property (split_on && step);
   bottom_update_c: cover property (ctrl.update_at_bottom && update);
   split_hi_c: cover property (EVENTS_OUT.compare_hi[0]);

endmodule

// ### sim/prescaler_event_model.sv
// Purpose: Far-side model: shared peripheral-clock prescaler and event lines
// Assumes: Same clock as the timer, synchronous active-high reset
// Notes:   Event lines are driven by the bench through ev_drive
`timescale 1ns/1ns
module prescaler_event_model
   import timer_counter_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic [NUM_EVENTS-1:0] ev_drive,
   output      logic [NUM_TAPS-1:0]   tick,
   output      logic [NUM_EVENTS-1:0] ev_out
);
   logic [10:0] div;

   ////////////////////////////////////////////////////////////////////////
   // Free-running divider, one shared by every timer in the device
   always_ff @(posedge clk) begin
      if (rst) begin
         div <= 11'h000;
      end else begin
         div <= div + 11'h001;
      end
   end

   // Tap k strobes once every 2^k cycles, tap 0 every cycle
   always_comb begin
      for (int k = 0; k < NUM_TAPS; k++) begin
         tick[k] = ((div & ((11'h001 << k) - 11'h001)) == 11'h000);
      end
   end

   // Event channels pass straight through, no added latency
   assign ev_out = ev_drive;
endmodule

// ### sim/tb.sv
// Purpose: Self-checking bench for the 16-bit timer/counter base
// Assumes: Register port with read data one cycle after the strobe
// Notes:   Steps come from event channel 0 so counts stay exact, except in the prescaler tap sweep
`timescale 1ns/1ns
module tb
   import timer_counter_pkg::*;
;
   logic                  CLK;
   logic                  RST;
   logic [ADDR_W-1:0]     ADDR;
   logic [DATA_W-1:0]     WDATA;
   logic                  WR;
   logic                  RD;
   logic [DATA_W-1:0]     RDATA;
   logic [NUM_TAPS-1:0]   tick;
   logic [NUM_EVENTS-1:0] ev_drive;
   logic [NUM_EVENTS-1:0] ev_in;
   events_s               evs;
   int                    fail_count;
   int                    comparisons;
   int                    cycles;
   int                    n_upd;
   int                    n_ovf;
   int                    n_cmp;
   int                    n_err;
   logic [15:0]           val;
   int                    n_hi;
   logic [15:0]           rdata_two;
   logic [15:0]           seen_two;

   timer_counter_base #(.FOUR_CHANNELS(1'b1)) DUT (.CLK(CLK), .RST(RST), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PRESCALE_TICK(tick),
      .EVENT_IN(ev_in), .EVENTS_OUT(evs));
   // Second type on the same bus: absent channels must read zero
   timer_counter_base #(.FOUR_CHANNELS(1'b0)) DUT_TWO (.CLK(CLK), .RST(RST), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(rdata_two), .PRESCALE_TICK(tick),
      .EVENT_IN(ev_in), .EVENTS_OUT());
   prescaler_event_model far (.clk(CLK), .rst(RST), .ev_drive(ev_drive), .tick(tick),
      .ev_out(ev_in));

   ////////////////////////////////////////////////////////////////////////
   // Clock, and a ceiling well above the prescaler sweep
   initial begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end
   always @(posedge CLK) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         fail_count = fail_count + 1;
         summarize();
      end
   end

   // Event pulse tallies, sampled away from reset
   always @(posedge CLK) begin
      if (!RST) begin
         n_upd = n_upd + int'(evs.update);
         n_ovf = n_ovf + int'(evs.overflow);
         n_cmp = n_cmp + int'(evs.compare[0]);
         n_err = n_err + int'(evs.error);
         n_hi = n_hi + int'(evs.compare_hi[0]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         fail_count = fail_count + 1;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // One-cycle write strobe, then released
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      @(negedge CLK);
      d = RDATA;
      seen_two = rdata_two;
   endtask

   task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
      logic [15:0] d;
      rd(a, d);
      check(d, exp);
   endtask

   // Event pulses with a gap, so each pulse is exactly one step
   task automatic step(input int n, input logic [3:0] pat);
      repeat (n) begin
         @(posedge CLK);
         ev_drive <= pat;
         @(posedge CLK);
         ev_drive <= 4'h0;
      end
      repeat (3) @(posedge CLK);
   endtask

   task automatic clr();
      n_upd = 0;
      n_ovf = 0;
      n_cmp = 0;
      n_err = 0;
      n_hi = 0;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      {RST, ADDR, WDATA, WR, RD, ev_drive} = '0;
      {fail_count, comparisons, cycles} = '0;
      clr();
      RST = 1'b1;
      repeat (3) @(posedge CLK);
      RST <= 1'b0;
      // Reset state, no source selected
      rdc(CTRL_ADDR, 16'h0000);
      rdc(PERIOD_ADDR, 16'hFFFF);
      rdc(PERIOD_BUF_ADDR, 16'hFFFF);
      rdc(CC_BASE_ADDR, 16'h0000);
      repeat (20) @(posedge CLK);
      rdc(COUNT_ADDR, 16'h0000);
      rdc(STATUS_ADDR, 16'h0040);
      wr(5'h0D, 16'h1234);
      rdc(5'h0D, 16'h0000);
      wr(STATUS_ADDR, 16'hFFFF);
      rdc(STATUS_ADDR, 16'h0040);
      wr(CC_BASE_ADDR + 5'h03, 16'h00AA);
      rdc(CC_BASE_ADDR + 5'h03, 16'h00AA);
      check(seen_two, 16'h0000);
      $display("Test reset and map done");
      // Up counting wraps after TOP
      clr();
      wr(PERIOD_ADDR, 16'h0002);
      wr(CTRL_ADDR, 16'h000C);
      step(5, 4'h1);
      rdc(COUNT_ADDR, 16'h0002);
      rdc(STATUS_ADDR, 16'h0120);
      check(16'(n_upd), 16'h0001);
      check(16'(n_ovf), 16'h0001);
      // Down counting reloads the period at zero
      wr(CTRL_ADDR, 16'h001C);
      wr(COUNT_ADDR, 16'h0001);
      step(3, 4'h1);
      rdc(COUNT_ADDR, 16'h0001);
      $display("Test count direction done");
      // Buffers set their flags and transfer on UPDATE
      wr(CTRL_ADDR, 16'h000C);
      wr(COUNT_ADDR, 16'h0000);
      wr(PERIOD_BUF_ADDR, 16'h0003);
      wr(CCBUF_BASE_ADDR, 16'h0001);
      rdc(STATUS_ADDR, 16'h0063);
      rdc(PERIOD_ADDR, 16'h0002);
      step(3, 4'h1);
      rdc(PERIOD_ADDR, 16'h0003);
      rdc(CC_BASE_ADDR, 16'h0001);
      rdc(STATUS_ADDR, 16'h0060);
      // Compare match fires once per pass, never in capture
      clr();
      step(4, 4'h1);
      check(16'(n_cmp), 16'h0001);
      wr(CTRL_ADDR, 16'h008C);
      step(4, 4'h1);
      check(16'(n_cmp), 16'h0001);
      $display("Test buffers and compare done");
      // Software write beats a step in the same cycle
      wr(CTRL_ADDR, 16'h000C);
      @(posedge CLK);
      ADDR <= COUNT_ADDR;
      WDATA <= 16'h0010;
      WR <= 1'b1;
      ev_drive <= 4'h1;
      @(posedge CLK);
      WR <= 1'b0;
      ev_drive <= 4'h0;
      rdc(COUNT_ADDR, 16'h0010);
      wr(CTRL_ADDR, 16'h0000);
      wr(COUNT_ADDR, 16'hFFFF);
      rdc(STATUS_ADDR, 16'h0080);
      // TOP taken from channel A compare
      wr(CC_BASE_ADDR, 16'h0005);
      wr(CTRL_ADDR, 16'h002C);
      wr(COUNT_ADDR, 16'h0003);
      step(3, 4'h1);
      rdc(COUNT_ADDR, 16'h0000);
      $display("Test override and TOP done");
      // Event up/down action and the misconfiguration flag
      clr();
      wr(CTRL_ADDR, 16'h0201);
      wr(CTRL_ADDR, 16'h020C);
      wr(PERIOD_ADDR, 16'hFFFF);
      wr(COUNT_ADDR, 16'h0000);
      step(2, 4'h3);
      step(1, 4'h1);
      rdc(COUNT_ADDR, 16'h0001);
      check(16'(n_err), 16'h0001);
      // Every prescaler tap, with a small phase tolerance
      for (int k = 0; k < NUM_TAPS; k++) begin
         wr(CTRL_ADDR, 16'h0000);
         wr(COUNT_ADDR, 16'h0000);
         wr(CTRL_ADDR, 16'(k + 1));
         repeat (2046) @(posedge CLK);
         wr(CTRL_ADDR, 16'h0000);
         rd(COUNT_ADDR, val);
         check(16'((val + 16'h0002 >= 16'(2048 >> k)) && (val <= 16'((2048 >> k) + 2))),
               16'h0001);
      end
      $display("Test sources done");
      // Split halves count down alone; no UPDATE while split
      clr();
      wr(PERIOD_ADDR, 16'h0201);
      wr(COUNT_ADDR, 16'h0000);
      wr(CTRL_ADDR, 16'h010C);
      step(3, 4'h1);
      rdc(COUNT_ADDR, 16'h0001);
      check(16'(n_hi), 16'h0001);
      check(16'(n_upd), 16'h0000);
      // UPDATE at BOTTOM copies the period buffer while counting down
      clr();
      wr(CTRL_ADDR, 16'h005C);
      wr(COUNT_ADDR, 16'h0001);
      wr(PERIOD_BUF_ADDR, 16'h0004);
      step(2, 4'h1);
      rdc(PERIOD_ADDR, 16'h0004);
      rdc(COUNT_ADDR, 16'h0201);
      check(16'(n_upd), 16'h0001);
      $display("Test split and bottom update done");
      summarize();
   end
endmodule
